// file: rtl/ipsq_regs.vh
// Constants of the interpolator serial sequencer device block.
// Assumes inclusion by bare name from the design files only.
// Functional notes
// - Every serial word is sixteen bits, most significant bit first.
// - Mode 0: clock idles low, sample on rise, change on fall.
// - Host polls PROM busy flag to zero; device holds it during PROM activity.
// - Device reports PROM present flag; host picks configuration path from it.
// - Two successive measured-value reads enable the trigger holding register.
// - Device sets index reference flag once index mark is passed.
// - Measured-value bit 0 flags error, mirrored on active-low fault output.
// - Measured-value bit 1 flags that a trigger event occurred.
// - Device reports error cause in condition register; host reads it.
// - Device-timed pending measurement gives falling edge on output A.
// - Host reads condition then measured value; condition shows trigger cause.
// - In device-timed mode, output A stays low while the stored value remains unread.
// - Presented value lags input sampling by exactly 125 system clocks.
`ifndef IPSQ_REGS_VH
`define IPSQ_REGS_VH

`define IPSQ_WORD_BITS 16
// Serial opcodes in word bits 15:12
`define IPSQ_OP_WRA 4'h8
`define IPSQ_OP_WRA_BC 4'h9
`define IPSQ_OP_WRD 4'hA
`define IPSQ_OP_WRD_BC 4'hB
`define IPSQ_OP_RDA 4'hC
// Serial register addresses
`define IPSQ_SA_IDREV 8'h00
`define IPSQ_SA_PROMSTAT 8'h01
`define IPSQ_SA_SETUP1 8'h02
`define IPSQ_SA_SETUP2 8'h03
`define IPSQ_SA_GAINST 8'h04
`define IPSQ_SA_OFFSST 8'h05
`define IPSQ_SA_MEASURED_VALUE_REGISTER 8'h06
`define IPSQ_SA_STAT 8'h07
`define IPSQ_SA_CMD 8'h08
`define IPSQ_SA_CNT 8'h09
// Command codes
`define IPSQ_CMD_SETHWADDR 8'h20
`define IPSQ_CMD_CLRCNT 8'h01
// Reset values
`define IPSQ_SETUP1_RST 8'h00
`define IPSQ_SETUP2_RST 8'h00
`define IPSQ_GAINST_RST 8'h00
`define IPSQ_OFFSST_RST 8'h00
// Measured-value bits
`define IPSQ_MV_ERR 0
`define IPSQ_MV_TRG 1
// Condition register bits
`define IPSQ_ST_ERR 0
`define IPSQ_ST_CAUSE_LSB 1
`define IPSQ_ST_TRG 4
`define IPSQ_ST_IDX 5
`define IPSQ_ST_HOLDEN 6
// Prom condition bits
`define IPSQ_PS_BUSY 0
`define IPSQ_PS_PRESENT 1
// Operating modes in setup word one bits 1:0
`define IPSQ_MODE_CPU 2'b00
`define IPSQ_MODE_TIMER 2'b01
// Avalon byte offsets
`define IPSQ_AV_CTRL 4'h0
`define IPSQ_AV_SAMPLE 4'h4
`define IPSQ_AV_ERR 4'h8
`define IPSQ_AV_STATUS 4'hC
// Timing
`define IPSQ_LAG_CYCLES 125
`define IPSQ_CLK_MHZ 125
`define IPSQ_TICK_NS 1000
`define IPSQ_TICK_CYCLES ((`IPSQ_TICK_NS * `IPSQ_CLK_MHZ) / 1000)
`define IPSQ_READY_CYCLES 32

`endif

// file: rtl/ipsq_sync.v
// Two-stage synchroniser for a group of asynchronous level inputs.
// Assumes one destination clock; each bit crosses independently.
`timescale 1ns/10ps
`default_nettype none
module ipsq_sync #(
   parameter W = 1,
   parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
   input wire core_clk_i,
   input wire rst_n_i,
   input wire [W-1:0] async_i,
   output reg [W-1:0] sync_o
);
   reg [W-1:0] meta_q;

   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_q <= RST_VAL;
         sync_o <= RST_VAL;
      end else begin
         meta_q <= async_i;
         sync_o <= meta_q;
      end
   end
endmodule
`default_nettype wire

// file: rtl/ipsq_delay.v
// Fixed-lag delay line held in a small ring memory with registered read.
// Assumes DELAY is at least 2 and below DEPTH.
`timescale 1ns/10ps
`default_nettype none
module ipsq_delay #(
   parameter W = 14,
   parameter AW = 7,
   parameter DELAY = 125
) (
   input wire core_clk_i,
   input wire rst_n_i,
   input wire [W-1:0] din_i,
   output reg [W-1:0] dout_o
);
   localparam [AW-1:0] RD_BACK = DELAY[AW-1:0] - 1'b1;
   reg [W-1:0] mem [0:(1<<AW)-1];
   reg [AW-1:0] wr_ptr_q;
   wire [AW-1:0] rd_ptr;

   // Read lands one cycle later, giving the full lag
   assign rd_ptr = wr_ptr_q - RD_BACK;

   always @(posedge core_clk_i) begin
      mem[wr_ptr_q] <= din_i;
   end

   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_q <= {AW{1'b0}};
         dout_o <= {W{1'b0}};
      end else begin
         wr_ptr_q <= wr_ptr_q + 1'b1;
         dout_o <= mem[rd_ptr];
      end
   end
endmodule
`default_nettype wire

// file: rtl/ipsq_top.v
// Interpolator serial device core: mode-0 word slave, measurement logic,
// Avalon-MM slave for sample input and control bits.
// Assumes all pin inputs are asynchronous to core_clk_i.
`timescale 1ns/10ps
`default_nettype none
`include "ipsq_regs.vh"
module ipsq_top #(
   parameter [15:0] PART_REVISION_REGISTER = 16'h0A5C, // Arbitrary identity value
   parameter PW = 14,
   parameter LAG = `IPSQ_LAG_CYCLES,
   parameter READY_CYCLES = `IPSQ_READY_CYCLES,
   parameter TICK_CYCLES = `IPSQ_TICK_CYCLES
) (
   input wire core_clk_i,
   input wire rst_n_i,
   // Avalon-MM slave
   input wire [3:0] avs_address_i,
   input wire avs_read_i,
   input wire avs_write_i,
   input wire [31:0] avs_writedata_i,
   input wire [3:0] avs_byteenable_i,
   output reg [31:0] avs_readdata_o,
   output wire avs_waitrequest_o,
   // Device pins
   input wire chip_reset_low_i,
   input wire serial_select_low_i,
   input wire sclk_i,
   input wire mosi_i,
   output reg miso_o,
   output reg miso_oe_n_o,
   input wire index_mark_i,
   input wire trigger_i,
   input wire [3:0] hw_addr_strap_i,
   output reg fault_low_o,
   output reg interrupt_request_low_o
);
   localparam PAD = 16 - PW;
   localparam [15:0] READY_N = READY_CYCLES[15:0];
   localparam [15:0] TICK_N = TICK_CYCLES[15:0];

   // Pin synchronisers reset to idle levels, so no false edge follows reset
   wire [5:0] pins_s;
   ipsq_sync #(.W(6), .RST_VAL(6'b100000)) u_sync (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .async_i({serial_select_low_i, chip_reset_low_i,
                sclk_i, mosi_i, index_mark_i, trigger_i}),
      .sync_o(pins_s)
   );
   wire [3:0] strap_s;
   ipsq_sync #(.W(4), .RST_VAL(4'h0)) u_sync_strap (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .async_i(hw_addr_strap_i),
      .sync_o(strap_s)
   );
   wire sel_n_s = pins_s[5];
   wire chip_rst_n_s = pins_s[4];
   wire sclk_s = pins_s[3];
   wire mosi_s = pins_s[2];
   wire idx_s = pins_s[1];
   wire trg_s = pins_s[0];

   reg sclk_q, sel_n_q, idx_q, trg_q;
   wire sclk_rise = sclk_s & ~sclk_q;
   wire sclk_fall = ~sclk_s & sclk_q;
   wire sel_start = ~sel_n_s & sel_n_q;
   wire idx_rise = idx_s & ~idx_q;
   wire trg_rise = trg_s & ~trg_q;

   // Avalon-side registers
   reg prom_present_q, prom_busy_q;
   reg [PW-1:0] sample_q;
   reg err_set_q;
   reg [2:0] err_code_q;
   reg av_ack_q;

   // Device state
   reg [15:0] ready_cnt_q;
   reg ready_q;
   reg [15:0] rx_q, tx_q;
   reg [4:0] bit_cnt_q;
   reg [7:0] addr_q;
   reg rd_pend_q;
   reg [3:0] hw_addr_q;
   reg [7:0] setup1_q, setup2_q, gainst_q, offsst_q;
   reg [PW-1:0] zero_q, held_q;
   reg pending_q, trg_flag_q, idx_ref_q, hold_en_q, err_q;
   reg [2:0] cause_q;
   reg mv_last_q;
   reg [15:0] tick_cnt_q;
   reg [7:0] period_cnt_q;

   wire [PW-1:0] lagged;
   ipsq_delay #(.W(PW), .AW(7), .DELAY(LAG)) u_lag (
      .core_clk_i(core_clk_i),
      .rst_n_i(rst_n_i),
      .din_i(sample_q),
      .dout_o(lagged)
   );
   wire [PW-1:0] pos_now = lagged - zero_q;

   // Word decode at sixteenth rising clock
   wire word_done = sclk_rise & ~sel_n_s & (bit_cnt_q == 5'd15);
   wire [15:0] word = {rx_q[14:0], mosi_s};
   wire [3:0] op = word[15:12];
   wire bcast = (op == `IPSQ_OP_WRA_BC) || (op == `IPSQ_OP_WRD_BC);
   wire hit = bcast || (word[11:8] == hw_addr_q);
   wire do_wra = word_done & hit &
                 ((op == `IPSQ_OP_WRA) || (op == `IPSQ_OP_WRA_BC));
   wire do_wrd = word_done & hit &
                 ((op == `IPSQ_OP_WRD) || (op == `IPSQ_OP_WRD_BC));
   wire do_rda = word_done & hit & (op == `IPSQ_OP_RDA);
   wire cmd_wr = do_wrd & (addr_q == `IPSQ_SA_CMD);
   wire clr_cmd = cmd_wr & (word[7:0] == `IPSQ_CMD_CLRCNT);
   wire load_rd = sel_start & rd_pend_q;
   wire mv_rd = load_rd & (addr_q == `IPSQ_SA_MEASURED_VALUE_REGISTER);

   // Measurement events
   wire tick = (tick_cnt_q == TICK_N - 16'd1);
   wire timer_fire = tick & (period_cnt_q == setup2_q);
   wire timed = (setup1_q[1:0] == `IPSQ_MODE_TIMER);
   wire meas_evt = hold_en_q & (timed ? timer_fire : trg_rise);

   // Serial read mux
   reg [15:0] rd_word;
   always @* begin
      rd_word = 16'h0000;
      if (addr_q == `IPSQ_SA_IDREV) begin
         rd_word = PART_REVISION_REGISTER;
      end else if (addr_q == `IPSQ_SA_PROMSTAT) begin
         rd_word[`IPSQ_PS_BUSY] = prom_busy_q;
         rd_word[`IPSQ_PS_PRESENT] = prom_present_q;
      end else if (addr_q == `IPSQ_SA_SETUP1) begin
         rd_word = {8'h00, setup1_q};
      end else if (addr_q == `IPSQ_SA_SETUP2) begin
         rd_word = {8'h00, setup2_q};
      end else if (addr_q == `IPSQ_SA_GAINST) begin
         rd_word = {8'h00, gainst_q};
      end else if (addr_q == `IPSQ_SA_OFFSST) begin
         rd_word = {8'h00, offsst_q};
      end else if (addr_q == `IPSQ_SA_MEASURED_VALUE_REGISTER) begin
         rd_word = {pending_q ? held_q : pos_now, {PAD{1'b0}}};
         rd_word[`IPSQ_MV_ERR] = err_q;
         rd_word[`IPSQ_MV_TRG] = trg_flag_q;
      end else if (addr_q == `IPSQ_SA_STAT) begin
         rd_word[`IPSQ_ST_ERR] = err_q;
         rd_word[`IPSQ_ST_CAUSE_LSB+2:`IPSQ_ST_CAUSE_LSB] = cause_q;
         rd_word[`IPSQ_ST_TRG] = trg_flag_q;
         rd_word[`IPSQ_ST_IDX] = idx_ref_q;
         rd_word[`IPSQ_ST_HOLDEN] = hold_en_q;
      end else if (addr_q == `IPSQ_SA_CNT) begin
         rd_word = {{PAD{1'b0}}, pos_now};
      end
   end

   // Edge history
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_q <= 1'b0;
         sel_n_q <= 1'b1;
         idx_q <= 1'b0;
         trg_q <= 1'b0;
      end else begin
         sclk_q <= sclk_s;
         sel_n_q <= sel_n_s;
         idx_q <= idx_s;
         trg_q <= trg_s;
      end
   end

   // Device logic, frozen by the chip reset pin, which resets flags, ready and bit counts, setup1_q and setup2_q
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ready_cnt_q <= 16'h0000;
         ready_q <= 1'b0;
         rx_q <= 16'h0000;
         tx_q <= 16'h0000;
         bit_cnt_q <= 5'd0;
         addr_q <= 8'h00;
         rd_pend_q <= 1'b0;
         hw_addr_q <= 4'h0;
         setup1_q <= `IPSQ_SETUP1_RST;
         setup2_q <= `IPSQ_SETUP2_RST;
         gainst_q <= `IPSQ_GAINST_RST;
         offsst_q <= `IPSQ_OFFSST_RST;
         zero_q <= {PW{1'b0}};
         held_q <= {PW{1'b0}};
         pending_q <= 1'b0;
         trg_flag_q <= 1'b0;
         idx_ref_q <= 1'b0;
         hold_en_q <= 1'b0;
         err_q <= 1'b0;
         cause_q <= 3'd0;
         mv_last_q <= 1'b0;
         tick_cnt_q <= 16'h0000;
         period_cnt_q <= 8'h00;
      end else if (!chip_rst_n_s) begin
         ready_cnt_q <= 16'h0000;
         ready_q <= 1'b0;
         bit_cnt_q <= 5'd0;
         rd_pend_q <= 1'b0;
         setup1_q <= `IPSQ_SETUP1_RST;
         setup2_q <= `IPSQ_SETUP2_RST;
         pending_q <= 1'b0;
         trg_flag_q <= 1'b0;
         idx_ref_q <= 1'b0;
         hold_en_q <= 1'b0;
         err_q <= 1'b0;
         mv_last_q <= 1'b0;
      end else begin
         // Not ready until startup count expires
         if (!ready_q) begin
            ready_cnt_q <= ready_cnt_q + 16'd1;
            ready_q <= (ready_cnt_q == READY_N - 16'd1);
         end
         // Mode-0 word shifter
         if (sel_n_s) begin
            bit_cnt_q <= 5'd0;
         end else if (sclk_rise) begin
            rx_q <= word;
            bit_cnt_q <= (bit_cnt_q == 5'd15) ? 5'd0 : bit_cnt_q + 5'd1;
         end
         if (sel_start) begin
            tx_q <= rd_pend_q ? rd_word : 16'h0000;
            rd_pend_q <= 1'b0;
         end else if (sclk_fall & ~sel_n_s) begin
            tx_q <= {tx_q[14:0], 1'b0};
         end
         if (do_wra || do_rda) begin
            addr_q <= word[7:0];
         end
         if (do_rda) begin
            rd_pend_q <= 1'b1;
         end
         if (do_wrd) begin
            if (addr_q == `IPSQ_SA_SETUP1) begin
               setup1_q <= word[7:0];
            end else if (addr_q == `IPSQ_SA_SETUP2) begin
               setup2_q <= word[7:0];
            end else if (addr_q == `IPSQ_SA_GAINST) begin
               gainst_q <= word[7:0];
            end else if (addr_q == `IPSQ_SA_OFFSST) begin
               offsst_q <= word[7:0];
            end
         end
         if (cmd_wr && word[7:0] == `IPSQ_CMD_SETHWADDR) begin
            hw_addr_q <= strap_s;
         end
         // Two back-to-back measured-value reads arm holding
         if (load_rd) begin
            mv_last_q <= mv_rd;
            if (mv_rd && mv_last_q) begin
               hold_en_q <= 1'b1;
            end
         end
         // Clear zeroes count and drops index reference
         if (clr_cmd) begin
            zero_q <= lagged;
         end
         if (idx_rise) begin
            idx_ref_q <= 1'b1;
         end else if (clr_cmd) begin
            idx_ref_q <= 1'b0;
         end
         // Error latch, new errors beat the clear
         if (err_set_q) begin
            err_q <= 1'b1;
            cause_q <= err_code_q;
         end else if (clr_cmd) begin
            err_q <= 1'b0;
         end
         // Trigger tick divider and period counter
         if (!timed || tick) begin
            tick_cnt_q <= 16'h0000;
         end else begin
            tick_cnt_q <= tick_cnt_q + 16'd1;
         end
         if (!timed || timer_fire) begin
            period_cnt_q <= 8'h00;
         end else if (tick) begin
            period_cnt_q <= period_cnt_q + 8'd1;
         end
         // Event storage; an event wins over the read that clears it
         if (meas_evt) begin
            held_q <= pos_now;
            pending_q <= 1'b1;
            trg_flag_q <= 1'b1;
         end else if (mv_rd) begin
            pending_q <= 1'b0;
            trg_flag_q <= 1'b0;
         end
      end
   end

   // Pin outputs
   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         miso_o <= 1'b0;
         miso_oe_n_o <= 1'b0;
         fault_low_o <= 1'b1;
         interrupt_request_low_o <= 1'b1;
      end else begin
         if (!ready_q || !chip_rst_n_s) begin
            miso_o <= 1'b0;
            miso_oe_n_o <= 1'b0;
         end else if (!sel_n_s) begin
            miso_o <= sel_start ? (rd_pend_q & rd_word[15]) : tx_q[15];
            miso_oe_n_o <= 1'b0;
         end else begin
            miso_o <= 1'b0;
            miso_oe_n_o <= 1'b1;
         end
         fault_low_o <= ~err_q;
         // Output A only interrupts in device-timed mode
         interrupt_request_low_o <= ~(timed & pending_q);
      end
   end

   // Avalon-MM slave, one wait cycle per access
   assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~av_ack_q;
   wire av_wr = avs_write_i & ~av_ack_q;
   wire av_rd = avs_read_i & ~av_ack_q;

   always @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         av_ack_q <= 1'b0;
         avs_readdata_o <= 32'h0000_0000;
         prom_present_q <= 1'b0;
         prom_busy_q <= 1'b0;
         sample_q <= {PW{1'b0}};
         err_set_q <= 1'b0;
         err_code_q <= 3'd0;
      end else begin
         av_ack_q <= (avs_read_i | avs_write_i) & ~av_ack_q;
         err_set_q <= 1'b0;
         if (av_wr && avs_byteenable_i[0]) begin
            if (avs_address_i == `IPSQ_AV_CTRL) begin
               prom_present_q <= avs_writedata_i[`IPSQ_PS_PRESENT];
               prom_busy_q <= avs_writedata_i[`IPSQ_PS_BUSY];
            end else if (avs_address_i == `IPSQ_AV_ERR) begin
               err_code_q <= avs_writedata_i[2:0];
               err_set_q <= (avs_writedata_i[2:0] != 3'd0);
            end
         end
         if (av_wr && avs_address_i == `IPSQ_AV_SAMPLE &&
             avs_byteenable_i[1:0] == 2'b11) begin
            sample_q <= avs_writedata_i[PW-1:0];
         end
         if (av_rd) begin
            if (avs_address_i == `IPSQ_AV_CTRL) begin
               avs_readdata_o <= {30'd0, prom_present_q, prom_busy_q};
            end else if (avs_address_i == `IPSQ_AV_SAMPLE) begin
               avs_readdata_o <= {{(32-PW){1'b0}}, sample_q};
            end else if (avs_address_i == `IPSQ_AV_STATUS) begin
               avs_readdata_o <= {12'd0, hw_addr_q, {(16-PW){1'b0}},
                                  pos_now} & 32'h000F_FFFF;
               avs_readdata_o[31:24] <= {ready_q, hold_en_q, idx_ref_q,
                                         pending_q, err_q, cause_q};
            end else begin
               avs_readdata_o <= 32'h0000_0000;
            end
         end
      end
   end
endmodule
`default_nettype wire

// file: tb/ipsq_top_sva.sv
// Port checker for the serial device core.
// Assumes binding to ipsq_top; all pins sampled on core_clk_i.
`timescale 1ns/10ps
`default_nettype none
module ipsq_top_sva (
   input wire logic core_clk_i,
   input wire logic rst_n_i,
   input wire logic [3:0] avs_address_i,
   input wire logic avs_read_i,
   input wire logic avs_write_i,
   input wire logic [31:0] avs_writedata_i,
   input wire logic [3:0] avs_byteenable_i,
   input wire logic avs_waitrequest_o,
   input wire logic chip_reset_low_i,
   input wire logic serial_select_low_i,
   input wire logic sclk_i,
   input wire logic miso_o,
   input wire logic miso_oe_n_o,
   input wire logic fault_low_o,
   input wire logic interrupt_request_low_o
);
   logic sclk_q;
   logic sel_q;
   logic [7:0] since_fall_q;
   logic [7:0] since_sel_q;
   // Raw pin edges; the core sees them about three cycles later
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sclk_q <= 1'b0;
         sel_q <= 1'b1;
         since_fall_q <= 8'hFF;
         since_sel_q <= 8'hFF;
      end else begin
         sclk_q <= sclk_i;
         sel_q <= serial_select_low_i;
         if ((sclk_q && !sclk_i) || (sel_q && !serial_select_low_i))
            since_fall_q <= 8'h00;
         else if (since_fall_q != 8'hFF)
            since_fall_q <= since_fall_q + 8'h01;
         if (!serial_select_low_i)
            since_sel_q <= 8'h00;
         else if (since_sel_q != 8'hFF)
            since_sel_q <= since_sel_q + 8'h01;
      end
   end
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);
   a_holdoff_held: assert property ((!chip_reset_low_i)[*4] |->
      !miso_oe_n_o && !miso_o) else $error("hold-off not low in reset");
   a_holdoff_min: assert property ($rose(chip_reset_low_i) |=>
      (!miso_oe_n_o)[*8]) else $error("hold-off released too early");
   a_holdoff_end: assert property ($rose(chip_reset_low_i) |->
      ##[30:45] (miso_oe_n_o || !serial_select_low_i))
      else $error("hold-off never released");
   a_fault_set: assert property (avs_write_i && !avs_waitrequest_o &&
      avs_address_i == 4'h8 && avs_byteenable_i[0] &&
      avs_writedata_i[2:0] != 3'h0 |-> ##[1:3] !fault_low_o)
      else $error("fault output not raised");
   a_fault_quiet: assert property ((!chip_reset_low_i)[*5] |->
      fault_low_o && interrupt_request_low_o)
      else $error("flags active during chip reset");
   a_miso_fall: assert property (!serial_select_low_i && !miso_oe_n_o &&
      $changed(miso_o) |-> since_fall_q <= 8'h08)
      else $error("serial output moved away from falling clock");
   a_pending_hold: assert property ((!interrupt_request_low_o &&
      serial_select_low_i && chip_reset_low_i)[*4] |=>
      !interrupt_request_low_o) else $error("pending dropped without read");
   a_pending_frame: assert property ($rose(interrupt_request_low_o) &&
      chip_reset_low_i |-> since_sel_q <= 8'h0A)
      else $error("pending released outside a frame");
   a_wait_one: assert property ((avs_read_i || avs_write_i) &&
      avs_waitrequest_o |=> !avs_waitrequest_o)
      else $error("bus answer later than one wait state");
   c_irq: cover property ($fell(interrupt_request_low_o));
   c_fault: cover property ($fell(fault_low_o));
   c_ready: cover property ($rose(chip_reset_low_i) ##[30:45] miso_oe_n_o);
endmodule
`default_nettype wire

// file: tb/ipsq_host_model.sv
// Host side of the serial link: mode-0 word master driven by tasks.
// Assumes the bench resolves the pulled-up data line for miso_i.
`timescale 1ns/10ps
`default_nettype none
module ipsq_host_model (
   input wire logic miso_i,
   output logic serial_select_low_o,
   output logic sclk_o,
   output logic mosi_o
);
   initial begin
      serial_select_low_o = 1'b1; // Deselected before anything
      sclk_o = 1'b0; // Clock idles low
      mosi_o = 1'b0;
   end
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      #3 serial_select_low_o = 1'b0; // Held low for the word
      for (int i = 15; i >= 0; i--) begin // Sixteen bits, top first
         mosi_o = w[i]; // Change while clock is low
         #40 sclk_o = 1'b1;
         r[i] = miso_i; // Sample on the rise
         #40 sclk_o = 1'b0;
      end
      #40 serial_select_low_o = 1'b1; // High between words
      mosi_o = ~mosi_o; // Stale bit must not look valid
      #117; // Frame spans whole 8 ns clocks, pins move off the edge
   endtask
endmodule
`default_nettype wire

// file: tb/ipsq_top_tb.sv
// Bench for the serial device core: host model, bus master, model checks.
// Assumes the checker and host model are compiled before this file.
`timescale 1ns/10ps
`default_nettype none
module ipsq_top_tb;
   localparam logic [15:0] ID = 16'h3C71; // Arbitrary identity value
   localparam int LAG = 125;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic crst_n = 1'b0; // Chip held in reset first
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic idx = 1'b0;
   logic trg = 1'b0;
   logic [3:0] adr = 4'h0;
   logic [3:0] strap = 4'h0;
   logic [3:0] ch = 4'h0;
   logic [31:0] wd = 32'h0000_0000;
   wire [31:0] rdat;
   wire wreq, sel_n, sck, mosi, miso_d, miso_oen, fault_n, irq_n;
   wire miso_w = miso_oen ? 1'b1 : miso_d; // Pull-up when released
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int mdl[int];
   ipsq_top #(.PART_REVISION_REGISTER(ID), .TICK_CYCLES(4)) ipsq_top_inst (
      .core_clk_i(clk), .rst_n_i(rst_n), .avs_address_i(adr),
      .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
      .avs_byteenable_i(4'hF), .avs_readdata_o(rdat),
      .avs_waitrequest_o(wreq), .chip_reset_low_i(crst_n),
      .serial_select_low_i(sel_n), .sclk_i(sck), .mosi_i(mosi),
      .miso_o(miso_d), .miso_oe_n_o(miso_oen), .index_mark_i(idx),
      .trigger_i(trg), .hw_addr_strap_i(strap), .fault_low_o(fault_n),
      .interrupt_request_low_o(irq_n));
   ipsq_host_model host_inst (.miso_i(miso_w),
      .serial_select_low_o(sel_n), .sclk_o(sck), .mosi_o(mosi));
   initial begin
      forever #4 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [31:0] e, s);
      n_checks++;
      if (s !== e) begin
         bad_count++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic av(input logic [3:0] a, input logic w,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk);
      adr <= a;
      wd <= d;
      wr <= w;
      rd <= ~w;
      do begin
         @(posedge clk);
         n++;
      end while (wreq !== 1'b0 && n < 50);
      q = rdat;
      wr <= 1'b0;
      rd <= 1'b0;
      if (n >= 50) chk("bus_wait", 0, 1);
   endtask
   // Second frame carries the answer; ID read keeps it side-effect free
   task automatic sreg(input logic [7:0] a, output logic [15:0] r);
      logic [15:0] x;
      host_inst.xfer({4'hC, ch, a}, x);
      host_inst.xfer({4'hC, ch, 8'h00}, r);
   endtask
   task automatic swr(input logic [7:0] a, input logic [7:0] d);
      logic [15:0] x;
      host_inst.xfer({4'h8, ch, a}, x);
      host_inst.xfer({4'hA, ch, d}, x);
   endtask
   task automatic tally_and_finish();
      $display("Checks %0d, mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 40000) begin
         chk("timeout", 0, 1);
         tally_and_finish();
      end
   end
   initial begin
      logic [15:0] r;
      logic [31:0] q;
      int n, s0, s1, c, v;
      logic pres;
      void'($urandom(62));
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      chk("holdoff_low", 0, miso_w);
      chk("fault_idle", 1, fault_n);
      strap <= 4'($urandom);
      crst_n <= 1'b1;
      n = 0;
      while (miso_w !== 1'b1 && n < 100) begin
         @(posedge clk);
         n++;
      end
      chk("holdoff_cycles", 1, n >= 32 && n <= 48);
      host_inst.xfer(16'h9008, r);
      host_inst.xfer(16'hB020, r);
      ch = strap;
      av(4'hC, 0, 0, q);
      chk("hw_addr", strap, q[19:16]);
      sreg(8'h00, r);
      chk("part_revision_register", ID, r);
      pres = 1'($urandom);
      av(4'h0, 1, 32'h0000_0003, q);
      sreg(8'h01, r);
      chk("prom_busy", 2'b11, r[1:0]);
      av(4'h0, 1, {30'h0, pres, 1'b0}, q);
      n = 0;
      r = 16'h0001;
      while (r[0] !== 1'b0 && n < 4) begin
         sreg(8'h01, r);
         n++;
      end
      chk("prom_ready", {pres, 1'b0}, r[1:0]);
      for (int a = 2; a <= 5; a++) begin
         v = $urandom_range(0, 255) & (a == 2 ? 8'hFC : 8'hFF);
         // Reset values are zero; with a PROM only differing words go out
         if (!pres || v != 0) swr(8'(a), 8'(v));
         mdl[a] = v;
      end
      for (int a = 2; a <= 5; a++) begin
         sreg(8'(a), r);
         chk("setup_readback", mdl[a], r[7:0]);
      end
      av(4'hC, 0, 0, q);
      chk("hold_en_before", 0, q[30]);
      host_inst.xfer({4'hC, ch, 8'h06}, r);
      sreg(8'h06, r);
      av(4'hC, 0, 0, q);
      chk("hold_en_after", 1, q[30]);
      s0 = $urandom_range(0, 16383);
      s1 = $urandom_range(0, 16383);
      av(4'h4, 1, s0, q);
      repeat (LAG + 10) @(posedge clk);
      swr(8'h08, 8'h01);
      av(4'hC, 0, 0, q);
      chk("count_clear", 0, {q[29], q[13:0]});
      av(4'h4, 1, s1, q); // Encoder moves after the clear
      repeat (LAG - 15) @(posedge clk);
      av(4'hC, 0, 0, q);
      chk("count_early", 0, q[13:0]);
      repeat (20) @(posedge clk);
      av(4'hC, 0, 0, q);
      chk("count_late", (s1 - s0) & 16'h3FFF, q[13:0]);
      sreg(8'h09, r);
      chk("count_serial", (s1 - s0) & 16'h3FFF, r);
      @(posedge clk);
      idx <= 1'b1;
      repeat (4) @(posedge clk);
      idx <= 1'b0;
      sreg(8'h07, r);
      chk("index_ref", 1, r[5]);
      c = $urandom_range(1, 7);
      av(4'h8, 1, c, q);
      repeat (3) @(posedge clk);
      chk("fault_pin", 0, fault_n);
      sreg(8'h06, r);
      chk("measured_value_register_err", 1, r[0]);
      sreg(8'h07, r);
      chk("err_cause", {c[2:0], 1'b1}, r[3:0]);
      swr(8'h08, 8'h01);
      sreg(8'h07, r);
      chk("recovered", 0, {r[5], r[0]});
      chk("fault_off", 1, fault_n);
      @(posedge clk);
      trg <= 1'b1;
      repeat (4) @(posedge clk);
      trg <= 1'b0;
      sreg(8'h06, r);
      chk("measured_value_register_trig", 2'b10, r[1:0]);
      chk("irq_cpu_mode", 1, irq_n);
      swr(8'h03, 8'hFF);
      swr(8'h02, 8'h01);
      n = 0;
      while (irq_n !== 1'b0 && n < 2000) begin
         @(posedge clk);
         n++;
      end
      chk("irq_fell", 0, irq_n);
      sreg(8'h07, r);
      chk("cond_trig", 1, r[4]);
      chk("irq_held", 0, irq_n);
      sreg(8'h06, r);
      chk("measured_value_register_timer", 1, r[1]);
      chk("irq_released", 1, irq_n);
      swr(8'h02, 8'h00);
      tally_and_finish();
   end
endmodule
bind ipsq_top ipsq_top_sva ipsq_top_sva_inst (.core_clk_i(core_clk_i),
   .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
   .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
   .avs_waitrequest_o(avs_waitrequest_o),
   .chip_reset_low_i(chip_reset_low_i),
   .serial_select_low_i(serial_select_low_i), .sclk_i(sclk_i),
   .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o), .fault_low_o(fault_low_o),
   .interrupt_request_low_o(interrupt_request_low_o));
`default_nettype wire
